// *** src/pbc_pkg.sv ***
package pbc_pkg;
  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int SOFT_RESET_NS = 1000;
  localparam int SOFT_RESET_CYC =
    (SOFT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // management addressing
  localparam logic [4:0] PHYAD_PORT1 = 5'h01;
  localparam logic [4:0] PHYAD_PORT3 = 5'h03;
  localparam logic [4:0] REGAD_BASIC_CTRL = 5'h00;
  localparam logic [4:0] REGAD_STD_LAST = 5'h05;
  localparam logic [4:0] REGAD_EXT_A = 5'h1d;
  localparam logic [4:0] REGAD_EXT_B = 5'h1f;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [5:0] PREAMBLE_ONES = 6'h20;

  // host (serial host port) register indices, one per port
  localparam logic [7:0] HOST_IDX_PORT1 = 8'h00;
  localparam int NUM_PORTS = 3;

  // basic control field positions
  localparam int BIT_SOFT_RESET = 15;
  localparam int BIT_LOOPBACK = 14;
  localparam int BIT_FORCE_100 = 13;
  localparam int BIT_AN_ENABLE = 12;
  localparam int BIT_POWER_DOWN = 11;
  localparam int BIT_ISOLATE = 10;
  localparam int BIT_AN_RESTART = 9;
  localparam int BIT_FULL_DUPLEX = 8;
  localparam int BIT_XOVER_STYLE = 5;
  localparam int BIT_FORCE_STRAIGHT = 4;
  localparam int BIT_XOVER_DISABLE = 3;
  localparam int BIT_FEF_DISABLE = 2;
  localparam int BIT_TX_DISABLE = 1;
  localparam int BIT_LED_DISABLE = 0;

  // reset value and writable bits (7 and 6 read as zero)
  localparam logic [15:0] CTRL_RESET = 16'h3120;
  localparam logic [15:0] CTRL_WR_MASK = 16'hff3f;

  typedef enum logic [2:0] {
    MS_IDLE = 3'b000,
    MS_HDR = 3'b001,
    MS_READ = 3'b010,
    MS_WRITE = 3'b011,
    MS_SKIP = 3'b100
  } pbc_mstate_e;
endpackage

// *** src/pbc_port_ctrl.sv ***
`timescale 1ns/1ps
module pbc_port_ctrl
  import pbc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // write port
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  // register contents
  output logic [15:0] ctrl_q
);
  logic [15:0] ctrl_d;
  logic [4:0] rst_cnt_q;
  logic [4:0] rst_cnt_d;
  wire busy = ctrl_q[BIT_SOFT_RESET];
  wire start_rst = wr_en && wr_data[BIT_SOFT_RESET] && !busy;
  wire plain_wr = wr_en && !wr_data[BIT_SOFT_RESET] && !busy;
  wire rst_done = busy && (rst_cnt_q == 5'h01);

  // soft reset reloads defaults and holds bit 15 until the count ends
  // writes during soft reset are dropped so the port comes up clean
  assign ctrl_d = start_rst ? (CTRL_RESET | 16'h8000) :
                  rst_done ? (ctrl_q & 16'h7dff) :
                  plain_wr ? (wr_data & CTRL_WR_MASK) :
                  (ctrl_q & 16'hfdff); // restart self-clears
  assign rst_cnt_d = start_rst ? 5'(SOFT_RESET_CYC) :
                     busy ? rst_cnt_q - 5'h01 : rst_cnt_q;

  // register with documented defaults
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RESET;
      rst_cnt_q <= 5'h00;
    end else begin
      ctrl_q <= ctrl_d;
      rst_cnt_q <= rst_cnt_d;
    end
  end

  AST_RESERVED_ZERO: assert property (
    @(posedge clk) disable iff (!rst_n) ctrl_q[7:6] == 2'h0)
    else $error("reserved control bits not zero");
  AST_RESTART_SELF_CLEAR: assert property (
    @(posedge clk) disable iff (!rst_n)
    ctrl_q[BIT_AN_RESTART] && !plain_wr |=> !ctrl_q[BIT_AN_RESTART])
    else $error("restart bit did not clear");
  AST_RESTART_SET: assert property (
    @(posedge clk) disable iff (!rst_n)
    plain_wr && wr_data[BIT_AN_RESTART] |=> ctrl_q[BIT_AN_RESTART])
    else $error("restart write not taken");
  AST_SOFT_RESET_LEN: assert property (
    @(posedge clk) disable iff (!rst_n)
    $rose(ctrl_q[BIT_SOFT_RESET]) |->
      ctrl_q[BIT_SOFT_RESET][*8] ##1 ctrl_q[BIT_SOFT_RESET][*2] ##1
      !ctrl_q[BIT_SOFT_RESET])
    else $error("soft reset length wrong");
  AST_SOFT_RESET_DEFAULTS: assert property (
    @(posedge clk) disable iff (!rst_n)
    $fell(ctrl_q[BIT_SOFT_RESET]) |-> ctrl_q == CTRL_RESET)
    else $error("defaults not restored by soft reset");
  AST_WRITE_TAKEN: assert property (
    @(posedge clk) disable iff (!rst_n)
    plain_wr |=> ctrl_q[14:10] == $past(wr_data[14:10]) &&
      ctrl_q[5:0] == $past(wr_data[5:0]))
    else $error("control write not stored");
endmodule

// *** src/pbc_top.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// - ports 1, 2, 3 answer management frames at PHY addresses 1, 2, 3
// - register addresses 0 to 5, 0x1d and 0x1f are answered per PHY
// - host port reaches every control register through its own index map
// - writing bit 15 soft-resets the port; it clears itself when done
// - bit 14 on port 1 loops other ports' frames at port 1 MAC
// - bit 14 on other addresses loops at that port; clearing restores normal
// - bit 13 forces 100 Mbps when 1, 10 Mbps when 0; resets to 1
// - bit 12 enables auto-negotiation, resets to 1; else forced bits rule
// - bit 11 powers the PHY down; resets to 0
// - bit 10 isolates the PHY from its line pairs; resets to 0
// - writing 1 to bit 9 restarts auto-negotiation; resets to 0
// - bit 8 forces full duplex when 1, half when 0; resets to 1
// - bit 5 picks crossover style, 1 alternate, 0 native; resets to 1
// - bit 3 disables auto crossover; then bit 4 forces straight or crossed
// - bit 2 disables far-end fault detection, bit 1 disables transmit
// - bit 0 turns the port's LEDs off; resets to 0
module pbc_top
  import pbc_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // management interface pins
  input wire logic MDC,
  input wire logic MDIO_IN,
  output logic MDIO_OUT,
  output logic MDIO_OE,
  // host register port
  input wire logic HOST_SEL,
  input wire logic HOST_WE,
  input wire logic [7:0] HOST_ADDR,
  input wire logic [15:0] HOST_WDATA,
  output logic [15:0] HOST_RDATA,
  // per-port controls, bit i is port i+1
  output logic [2:0] PHY_SOFT_RESET,
  output logic [2:0] MAC_LOOPBACK,
  output logic [2:0] FORCE_100,
  output logic [2:0] AN_ENABLE,
  output logic [2:0] POWER_DOWN,
  output logic [2:0] PHY_ISOLATE,
  output logic [2:0] AN_RESTART,
  output logic [2:0] FULL_DUPLEX,
  output logic [2:0] CROSSOVER_STYLE_SELECT,
  output logic [2:0] FORCE_STRAIGHT,
  output logic [2:0] XOVER_DISABLE,
  output logic [2:0] FEF_DISABLE,
  output logic [2:0] TX_DISABLE,
  output logic [2:0] LED_DISABLE
);
  logic [2:0] mdc_sync_q;
  logic [2:0] mdi_sync_q;
  logic mdc_lvl_q;
  logic mdi_lvl_q;
  pbc_mstate_e state_q;
  pbc_mstate_e state_d;
  logic [5:0] ones_q;
  logic [4:0] cnt_q;
  logic [15:0] sh_q;
  logic [15:0] rd_sh_q;
  logic [1:0] port_q;
  logic ctrl_sel_q;
  logic [15:0] ctrl_w [NUM_PORTS];
  logic [2:0] wr_en_w;
  logic [15:0] wr_data_w [NUM_PORTS];

  // pin synchronisers; a level counts once stages two and three agree
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      mdc_sync_q <= 3'h0;
      mdi_sync_q <= 3'h0;
      mdc_lvl_q <= 1'b0;
      mdi_lvl_q <= 1'b0;
    end else begin
      mdc_sync_q <= {mdc_sync_q[1:0], MDC};
      mdi_sync_q <= {mdi_sync_q[1:0], MDIO_IN};
      if (mdc_sync_q[1] == mdc_sync_q[2])
        mdc_lvl_q <= mdc_sync_q[2];
      if (mdi_sync_q[1] == mdi_sync_q[2])
        mdi_lvl_q <= mdi_sync_q[2];
    end
  end

  // frame decoding
  wire mdc_edge = (mdc_sync_q[1] == mdc_sync_q[2]) && mdc_sync_q[2] &&
                  !mdc_lvl_q;
  wire bit_in = mdi_lvl_q;
  wire [15:0] sh_next = {sh_q[14:0], bit_in};
  wire [1:0] hdr_op = sh_next[11:10];
  wire [4:0] hdr_phy = sh_next[9:5];
  wire [4:0] hdr_reg = sh_next[4:0];
  wire phy_ok = (hdr_phy >= PHYAD_PORT1) && (hdr_phy <= PHYAD_PORT3);
  wire reg_ok = (hdr_reg <= REGAD_STD_LAST) || (hdr_reg == REGAD_EXT_A) ||
                (hdr_reg == REGAD_EXT_B);
  wire hdr_good = sh_next[12] && phy_ok && reg_ok;
  wire hdr_end = (state_q == MS_HDR) && (cnt_q == 5'd12);
  wire [1:0] hdr_port = 2'(hdr_phy - PHYAD_PORT1);
  // only the control register lives here; the rest of the set reads zero
  wire [15:0] hdr_rdata =
    (hdr_reg == REGAD_BASIC_CTRL) ? ctrl_w[hdr_port] : 16'h0000;
  wire miim_wr = mdc_edge && (state_q == MS_WRITE) && (cnt_q == 5'd17);

  // next state of the frame walker
  always_comb begin
    state_d = state_q;
    if (mdc_edge) begin
      case (state_q)
        MS_IDLE: if (!bit_in && ones_q >= PREAMBLE_ONES) state_d = MS_HDR;
        MS_HDR: if (cnt_q == 5'd12) state_d = !hdr_good ? MS_SKIP :
                  (hdr_op == OP_READ) ? MS_READ :
                  (hdr_op == OP_WRITE) ? MS_WRITE : MS_SKIP;
        MS_READ, MS_WRITE, MS_SKIP: if (cnt_q == 5'd17) state_d = MS_IDLE;
        default: state_d = MS_IDLE;
      endcase
    end
  end

  // walker registers and pin drive; the pin changes just after MDC rises
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= MS_IDLE;
      ones_q <= 6'h00;
      cnt_q <= 5'h00;
      sh_q <= 16'h0000;
      rd_sh_q <= 16'h0000;
      port_q <= 2'h0;
      ctrl_sel_q <= 1'b0;
      MDIO_OUT <= 1'b0;
      MDIO_OE <= 1'b0;
    end else if (mdc_edge) begin
      state_q <= state_d;
      sh_q <= sh_next;
      cnt_q <= (state_d != state_q) ? 5'h00 : cnt_q + 5'h01;
      if (state_q == MS_IDLE)
        ones_q <= !bit_in ? 6'h00 :
                  (ones_q == PREAMBLE_ONES) ? ones_q : ones_q + 6'h01;
      else
        ones_q <= 6'h00;
      // latch target only for good headers; a foreign address has no port
      if (hdr_end && hdr_good) begin
        rd_sh_q <= hdr_rdata;
        port_q <= hdr_port;
        ctrl_sel_q <= (hdr_reg == REGAD_BASIC_CTRL);
      end
      if (state_q == MS_READ) begin
        MDIO_OE <= (cnt_q != 5'd17);
        MDIO_OUT <= (cnt_q == 5'd0) ? 1'b0 : rd_sh_q[15];
        if (cnt_q != 5'd0)
          rd_sh_q <= {rd_sh_q[14:0], 1'b0};
      end
    end
  end

  // host port reads, answer one cycle after the request
  wire [7:0] host_rel = HOST_ADDR - HOST_IDX_PORT1;
  wire host_hit = host_rel < 8'(NUM_PORTS);
  wire [1:0] host_port = host_rel[1:0];
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N)
      HOST_RDATA <= 16'h0000;
    else if (HOST_SEL && !HOST_WE)
      HOST_RDATA <= host_hit ? ctrl_w[host_port] : 16'h0000;
  end

  // per-port registers; management writes win a same-cycle collision
  for (genvar i = 0; i < NUM_PORTS; i++) begin : g_port
    wire m_hit = miim_wr && (port_q == 2'(i)) &&
                 ctrl_sel_q; // register 0 only
    wire h_hit = HOST_SEL && HOST_WE && host_hit && (host_port == 2'(i));
    assign wr_en_w[i] = m_hit || h_hit;
    assign wr_data_w[i] = m_hit ? sh_next : HOST_WDATA;
    pbc_port_ctrl u_ctrl (
      .clk(CLK),
      .rst_n(RST_N),
      .wr_en(wr_en_w[i]),
      .wr_data(wr_data_w[i]),
      .ctrl_q(ctrl_w[i])
    );
    // field fan-out, each straight from the port register
    assign PHY_SOFT_RESET[i] = ctrl_w[i][BIT_SOFT_RESET];
    assign MAC_LOOPBACK[i] = ctrl_w[i][BIT_LOOPBACK];
    assign FORCE_100[i] = ctrl_w[i][BIT_FORCE_100];
    assign AN_ENABLE[i] = ctrl_w[i][BIT_AN_ENABLE];
    assign POWER_DOWN[i] = ctrl_w[i][BIT_POWER_DOWN];
    assign PHY_ISOLATE[i] = ctrl_w[i][BIT_ISOLATE];
    assign AN_RESTART[i] = ctrl_w[i][BIT_AN_RESTART];
    assign FULL_DUPLEX[i] = ctrl_w[i][BIT_FULL_DUPLEX];
    assign CROSSOVER_STYLE_SELECT[i] = ctrl_w[i][BIT_XOVER_STYLE];
    assign FORCE_STRAIGHT[i] = ctrl_w[i][BIT_FORCE_STRAIGHT];
    assign XOVER_DISABLE[i] = ctrl_w[i][BIT_XOVER_DISABLE];
    assign FEF_DISABLE[i] = ctrl_w[i][BIT_FEF_DISABLE];
    assign TX_DISABLE[i] = ctrl_w[i][BIT_TX_DISABLE];
    assign LED_DISABLE[i] = ctrl_w[i][BIT_LED_DISABLE];
  end

  AST_IDLE_NO_DRIVE: assert property (
    @(posedge CLK) disable iff (!RST_N) state_q == MS_IDLE |-> !MDIO_OE)
    else $error("management pin driven while idle");
  AST_BAD_ADDR_SKIPPED: assert property (
    @(posedge CLK) disable iff (!RST_N)
    mdc_edge && hdr_end && !(phy_ok && reg_ok) |=> state_q == MS_SKIP)
    else $error("frame for foreign address not skipped");
  AST_HOST_READ: assert property (
    @(posedge CLK) disable iff (!RST_N)
    HOST_SEL && !HOST_WE && HOST_ADDR == HOST_IDX_PORT1 |=>
      HOST_RDATA == $past(ctrl_w[0]))
    else $error("host read of port 1 wrong");
  AST_TA_DRIVE_ZERO: assert property (
    @(posedge CLK) disable iff (!RST_N)
    mdc_edge && state_q == MS_READ && cnt_q == 5'd0 |=> MDIO_OE && !MDIO_OUT)
    else $error("turnaround not driven low");
  AST_READ_RELEASE: assert property (
    @(posedge CLK) disable iff (!RST_N)
    mdc_edge && state_q == MS_READ && cnt_q == 5'd17 |=> !MDIO_OE)
    else $error("pin not released after read data");
  AST_HOST_UNMAPPED: assert property (
    @(posedge CLK) disable iff (!RST_N)
    HOST_SEL && !HOST_WE && !host_hit |=> HOST_RDATA == 16'h0000)
    else $error("unmapped host read not zero");
  AST_MGMT_WRITE_ONLY_CTRL: assert property (
    @(posedge CLK) disable iff (!RST_N)
    miim_wr && !ctrl_sel_q && !HOST_SEL |-> wr_en_w == 3'h0)
    else $error("management write hit a control register");
endmodule

// *** bench/pbc_mgmt_model.sv ***
`timescale 1ns/1ps
// station controller model; mdc stands low between frames
module pbc_mgmt_model
  import pbc_pkg::*;
(
  // system clock paces the slow management clock
  input wire logic clk,
  // wire level in, our drive out
  input wire logic mdio,
  output logic mdc,
  output logic m_oe,
  output logic m_bit
);
  // idle: clock low, data line left to the pull-up
  initial begin
    mdc = 1'b0;
    m_oe = 1'b0;
    m_bit = 1'b1;
  end
  // 8 clk per half keeps each bit well past the 3-4 clk sync lag
  task automatic half();
    repeat (8) @(negedge clk);
  endtask
  task automatic put(input logic b);
    m_oe = 1'b1;
    m_bit = b;
    half();
    mdc = 1'b1;
    half();
    mdc = 1'b0;
  endtask
  // one frame; rd and drv only mean something for reads
  task automatic frame(input logic [1:0] op, input logic [4:0] pa,
    input logic [4:0] ra, input logic [15:0] wd,
    output logic [15:0] rd, output logic drv);
    logic [31:0] w;
    logic [17:0] s;
    int i;
    w = {2'b01, op, pa, ra, 2'b10, wd};
    for (i = 0; i < 32; i++) put(1'b1);
    for (i = 31; i >= 18; i--) put(w[i]);
    if (op == OP_WRITE) begin
      for (i = 17; i >= 0; i--) put(w[i]);
    end else begin
      m_oe = 1'b0;  // release before turnaround
      for (i = 17; i >= 0; i--) begin
        half();
        s[i] = mdio;
        mdc = 1'b1;
        half();
        mdc = 1'b0;
      end
    end
    m_oe = 1'b0;
    // let the release stand before the next preamble drives again
    half();
    rd = s[15:0];
    drv = (s[17:16] === 2'b10);
  endtask
endmodule

// *** bench/phy_port_basic_control_regs_tb_top.sv ***
`timescale 1ns/1ps
module phy_port_basic_control_regs_tb_top
  import pbc_pkg::*;
();
  logic clk, rst_n, mdc, mdio_in, mdio_out, mdio_oe, sel, we, m_oe, m_bit;
  logic [7:0] addr;
  logic [15:0] wdata, rdata;
  logic [2:0] srst, lpbk, f100, anen, pdn, iso, anrs, fdx;
  logic [2:0] xsty, fstr, xdis, fefd, txd, ledd;
  logic [15:0] mdl [3];
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  int seed = 85035;
  // data line has a pull-up when nobody drives it
  assign mdio_in = mdio_oe ? mdio_out : (m_oe ? m_bit : 1'b1);
  pbc_top pbc_top_i (.CLK(clk), .RST_N(rst_n), .MDC(mdc),
    .MDIO_IN(mdio_in), .MDIO_OUT(mdio_out), .MDIO_OE(mdio_oe),
    .HOST_SEL(sel), .HOST_WE(we), .HOST_ADDR(addr),
    .HOST_WDATA(wdata), .HOST_RDATA(rdata), .PHY_SOFT_RESET(srst),
    .MAC_LOOPBACK(lpbk), .FORCE_100(f100), .AN_ENABLE(anen),
    .POWER_DOWN(pdn), .PHY_ISOLATE(iso), .AN_RESTART(anrs),
    .FULL_DUPLEX(fdx), .CROSSOVER_STYLE_SELECT(xsty),
    .FORCE_STRAIGHT(fstr), .XOVER_DISABLE(xdis), .FEF_DISABLE(fefd),
    .TX_DISABLE(txd), .LED_DISABLE(ledd));
  pbc_mgmt_model pbc_mgmt_model_i (.clk(clk), .mdio(mdio_in),
    .mdc(mdc), .m_oe(m_oe), .m_bit(m_bit));
  // 10 MHz system clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // a hang costs a mismatch; the whole run needs about 14k cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e,
    input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // control pins laid out in register order, 7 and 6 as zero
  task automatic chk_pins(input int p);
    chk("pins", mdl[p], {srst[p], lpbk[p], f100[p], anen[p], pdn[p],
      iso[p], anrs[p], fdx[p], 2'b00, xsty[p], fstr[p], xdis[p],
      fefd[p], txd[p], ledd[p]});
  endtask
  // host strobe is one cycle; an idle edge first, so a strobe is never
  // lowered and raised again in one time step
  task automatic hwr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk);
    sel = 1'b1;
    we = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    sel = 1'b0;
    we = 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
    @(negedge clk);
    sel = 1'b1;
    addr = a;
    @(negedge clk);
    sel = 1'b0;
    chk("host read", e, rdata);
  endtask
  initial begin
    logic [15:0] d, rd;
    logic [7:0] a;
    logic drv, ok;
    int i, p, n;
    {sel, we, addr, wdata} = '0;
    rst_n = 1'b0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    for (p = 0; p < 3; p++) mdl[p] = CTRL_RESET;
    for (p = 0; p < 3; p++) begin
      rdchk(8'(p), mdl[p]);
      chk_pins(p);
    end
    $display("test reset done");
    // random words, low index bits 3 fall on unmapped places
    for (i = 0; i < 40; i++) begin
      a = 8'($random(seed));
      if (a[1:0] != 2'h3) a = {6'h0, a[1:0]};
      d = 16'($random(seed));
      d[15] = 1'b0;
      d[9] = 1'b0;
      hwr(a, d);
      if (a < 3) mdl[a] = d & CTRL_WR_MASK;
      rdchk(a, a < 3 ? mdl[a] : 16'h0);
      if (a < 3) chk_pins(a);
    end
    $display("test host done");
    // second write lands while reset runs and must be dropped
    for (p = 0; p < 3; p++) begin
      hwr(8'(p), 16'h8000);
      n = cyc;
      hwr(8'(p), 16'h0000);
      while (srst[p] === 1'b1 && cyc - n < 40) @(negedge clk);
      chk("srst cycles", 16'(SOFT_RESET_CYC), 16'(cyc - n));
      mdl[p] = CTRL_RESET;
      rdchk(8'(p), mdl[p]);
    end
    $display("test soft reset done");
    for (p = 0; p < 3; p++) begin
      hwr(8'(p), mdl[p] | 16'h0200);
      chk("an pulse", 16'h1, {15'h0, anrs[p]});
      @(negedge clk);
      chk("an clear", 16'h0, {15'h0, anrs[p]});
      rdchk(8'(p), mdl[p]);
    end
    $display("test restart done");
    // addresses 0 and 4 lie outside the bank
    for (p = 0; p < 5; p++) begin
      ok = (p > 0 && p < 4);
      pbc_mgmt_model_i.frame(OP_READ, 5'(p), REGAD_BASIC_CTRL, 16'h0,
        rd, drv);
      chk("mdio drive", {15'h0, ok}, {15'h0, drv});
      if (ok) chk("mdio read", mdl[p-1], rd);
      d = 16'($random(seed)) & 16'h7dff;
      pbc_mgmt_model_i.frame(OP_WRITE, 5'(p), REGAD_BASIC_CTRL, d, rd,
        drv);
      if (ok) mdl[p-1] = d & CTRL_WR_MASK;
    end
    pbc_mgmt_model_i.frame(OP_READ, 5'h02, REGAD_EXT_A, 16'h0, rd, drv);
    chk("ext read", 16'h0, rd);
    pbc_mgmt_model_i.frame(OP_WRITE, 5'h02, REGAD_EXT_B, 16'hffff, rd,
      drv);
    pbc_mgmt_model_i.frame(OP_READ, 5'h02, 5'h06, 16'h0, rd, drv);
    chk("bad reg drive", 16'h0, {15'h0, drv});
    for (p = 0; p < 3; p++) begin
      rdchk(8'(p), mdl[p]);
      chk_pins(p);
    end
    $display("test mgmt done");
    test_done();
  end
endmodule
